// File: irq_bank_params.svh
// register offsets, field positions and reset values of the interrupt flag and enable bank
`ifndef IRQ_BANK_PARAMS_SVH
`define IRQ_BANK_PARAMS_SVH

`define OFS_EDGE_SELECT     4'h0
`define OFS_CONTROL_A       4'h4
`define OFS_CONTROL_B       4'h8
`define OFS_SHARED_A        4'hC
`define OFS_EVT_STATUS      5'h10
`define OFS_EVT_MASK        5'h14

`define EDGE_PIN_B_HI       3
`define EDGE_PIN_A_HI       1
`define EDGE_MASK           8'h0F

`define CA_GLOBAL_EN        0
`define CA_PIN_A_EN         1
`define CA_PIN_B_EN         2
`define CA_TB0_EN           3
`define CA_PIN_A_FLAG       4
`define CA_PIN_B_FLAG       5
`define CA_TB0_FLAG         6
`define CA_MASK             8'h7F

`define CB_TB1_EN           0
`define CB_SV0_EN           1
`define CB_TB1_FLAG         4
`define CB_SV0_FLAG         5

`define SA_T0P              4
`define SA_T2P              6
`define SA_MASK_SMALL       8'h33
`define SA_MASK_LARGE       8'hFF

`define REG_RESET           8'h00
`define NUM_EVT             4
`define NUM_VEC             8

`endif

// File: irq_bank_pkg.sv
// types shared by the interrupt flag and enable bank
package irq_bank_pkg;
    typedef enum logic [1:0] {
        EDGE_OFF     = 2'h0,
        EDGE_RISING  = 2'h1,
        EDGE_FALLING = 2'h2,
        EDGE_BOTH    = 2'h3
    } edge_mode_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'h0,
        BUS_ACK  = 2'h1
    } bus_state_t;
endpackage

// File: pin_edge_detect.sv
// external pin synchroniser with selectable trigger edge
`timescale 1ns/1ps
`include "irq_bank_params.svh"
module pin_edge_detect (
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    input  wire logic                      ce_i,
    input  wire logic                      pin_i,
    input  wire irq_bank_pkg::edge_mode_t  mode_i,
    output logic                           edge_o
);
    logic sync_a;
    logic sync_b;
    logic prev;
    logic next_sync_a;
    logic next_sync_b;
    logic next_prev;

    always_comb begin
        next_sync_a = pin_i;
        next_sync_b = sync_a;
        next_prev   = sync_b;
        case (mode_i)
            irq_bank_pkg::EDGE_RISING:  edge_o = sync_b & ~prev;
            irq_bank_pkg::EDGE_FALLING: edge_o = ~sync_b & prev;
            irq_bank_pkg::EDGE_BOTH:    edge_o = sync_b ^ prev;
            default:                    edge_o = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            prev   <= 1'b0;
        end else if (ce_i) begin
            sync_a <= next_sync_a;
            sync_b <= next_sync_b;
            prev   <= next_prev;
        end
    end
endmodule

// File: vector_select.sv
// fixed-priority pick of the lowest-numbered pending and enabled vector
`timescale 1ns/1ps
`include "irq_bank_params.svh"
module vector_select (
    input  wire logic [`NUM_VEC-1:0] active_i,
    output logic                     any_o,
    output logic [2:0]               index_o
);
    always_comb begin
        any_o   = 1'b0;
        index_o = 3'h0;
        for (int i = `NUM_VEC - 1; i >= 0; i--) begin
            if (active_i[i]) begin
                any_o   = 1'b1;
                index_o = 3'(i);
            end
        end
    end
endmodule

// File: mcu_interrupt_flag_enable_bank.sv
// interrupt request and enable register bank with classic wishbone slave
//
// Our own choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "irq_bank_params.svh"
module mcu_interrupt_flag_enable_bank #(
    parameter bit LARGE_PART = 1'b1
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [4:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    input  wire logic        ext_irq_pin_a_i,
    input  wire logic        ext_irq_pin_b_i,
    input  wire logic        time_base_zero_evt_i,
    input  wire logic        time_base_one_evt_i,
    input  wire logic        timer_zero_cmp_p_evt_i,
    input  wire logic        timer_zero_cmp_a_evt_i,
    input  wire logic        timer_two_cmp_p_evt_i,
    input  wire logic        timer_two_cmp_a_evt_i,
    input  wire logic        shared_vec_one_src_i,
    input  wire logic        shared_vec_two_src_i,
    input  wire logic        service_enter_i,
    input  wire logic        service_done_i,
    output logic             core_irq_req_o,
    output logic [2:0]       core_irq_vector_o,
    output logic             irq_o
);
    logic [7:0] ext_edge_select;
    logic [7:0] primary_irq_control_a;
    logic [7:0] primary_irq_control_b;
    logic [7:0] shared_irq_group_a;
    logic [`NUM_EVT-1:0] evt_status;
    logic [`NUM_EVT-1:0] evt_mask;
    irq_bank_pkg::bus_state_t bus_state;
    logic [31:0] rd_data;

    logic [7:0] next_ext_edge_select;
    logic [7:0] next_control_a;
    logic [7:0] next_control_b;
    logic [7:0] next_shared_a;
    logic [`NUM_EVT-1:0] next_evt_status;
    logic [`NUM_EVT-1:0] next_evt_mask;
    irq_bank_pkg::bus_state_t next_bus_state;
    logic [31:0] next_rd_data;

    logic pin_a_edge;
    logic pin_b_edge;
    logic [`NUM_VEC-1:0] active;
    logic [2:0] pick;
    logic pick_any;
    logic wr_req;
    logic rd_req;

    // small part keeps only timer zero bits
    function automatic logic [7:0] shared_mask();
        return LARGE_PART ? `SA_MASK_LARGE : `SA_MASK_SMALL;
    endfunction

    // byte lane 0 carries every register; other lanes are ignored
    function automatic logic [7:0] wr_merge(input logic [7:0] cur, input logic [7:0] mask);
        return (sel_i[0] ? dat_i[7:0] : cur) & mask;
    endfunction

    pin_edge_detect u_pin_a (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .ce_i   (ce_i),
        .pin_i  (ext_irq_pin_a_i),
        .mode_i (irq_bank_pkg::edge_mode_t'(ext_edge_select[`EDGE_PIN_A_HI -: 2])),
        .edge_o (pin_a_edge)
    );

    pin_edge_detect u_pin_b (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .ce_i   (ce_i),
        .pin_i  (ext_irq_pin_b_i),
        .mode_i (irq_bank_pkg::edge_mode_t'(ext_edge_select[`EDGE_PIN_B_HI -: 2])),
        .edge_o (pin_b_edge)
    );

    // vector order follows priority: pin a first, shared vector two last
    always_comb begin
        active[0] = primary_irq_control_a[`CA_PIN_A_FLAG] & primary_irq_control_a[`CA_PIN_A_EN];
        active[1] = primary_irq_control_a[`CA_PIN_B_FLAG] & primary_irq_control_a[`CA_PIN_B_EN];
        active[2] = primary_irq_control_a[`CA_TB0_FLAG] & primary_irq_control_a[`CA_TB0_EN];
        active[3] = primary_irq_control_b[`CB_TB1_FLAG] & primary_irq_control_b[`CB_TB1_EN];
        for (int i = 0; i < 3; i++) begin
            active[4 + i] = primary_irq_control_b[`CB_SV0_FLAG + i] & primary_irq_control_b[`CB_SV0_EN + i];
        end
        active[7] = 1'b0;
    end

    vector_select u_pick (
        .active_i (active),
        .any_o    (pick_any),
        .index_o  (pick)
    );

    assign core_irq_req_o    = pick_any & primary_irq_control_a[`CA_GLOBAL_EN];
    assign core_irq_vector_o = pick;
    assign irq_o             = |(evt_status & evt_mask);
    assign ack_o             = (bus_state == irq_bank_pkg::BUS_ACK);
    assign dat_o             = rd_data;
    assign wr_req            = cyc_i & stb_i & we_i & (bus_state == irq_bank_pkg::BUS_IDLE) & ce_i;
    assign rd_req            = cyc_i & stb_i & ~we_i & (bus_state == irq_bank_pkg::BUS_IDLE) & ce_i;

    always_comb begin
        logic [7:0] sa_evt;
        logic [7:0] ca_evt;
        logic [7:0] cb_evt;
        sa_evt = 8'h00;
        ca_evt = 8'h00;
        cb_evt = 8'h00;
        next_ext_edge_select = ext_edge_select;
        next_control_a       = primary_irq_control_a;
        next_control_b       = primary_irq_control_b;
        next_shared_a        = shared_irq_group_a;
        next_evt_status      = evt_status;
        next_evt_mask        = evt_mask;
        next_bus_state       = irq_bank_pkg::BUS_IDLE;
        next_rd_data         = rd_data;

        // flags rise whatever their enable says
        sa_evt[`SA_T0P]     = timer_zero_cmp_p_evt_i;
        sa_evt[`SA_T0P + 1] = timer_zero_cmp_a_evt_i;
        sa_evt[`SA_T2P]     = timer_two_cmp_p_evt_i;
        sa_evt[`SA_T2P + 1] = timer_two_cmp_a_evt_i;
        sa_evt              = sa_evt & shared_mask();
        ca_evt[`CA_PIN_A_FLAG] = pin_a_edge;
        ca_evt[`CA_PIN_B_FLAG] = pin_b_edge;
        ca_evt[`CA_TB0_FLAG]   = time_base_zero_evt_i;
        cb_evt[`CB_TB1_FLAG]   = time_base_one_evt_i;
        // shared vector zero follows its enabled sub-sources; one and two come from other groups
        cb_evt[`CB_SV0_FLAG]     = |(shared_irq_group_a[7:4] & shared_irq_group_a[3:0]);
        cb_evt[`CB_SV0_FLAG + 1] = shared_vec_one_src_i;
        cb_evt[`CB_SV0_FLAG + 2] = shared_vec_two_src_i;

        if (wr_req) begin
            next_bus_state = irq_bank_pkg::BUS_ACK;
            case (adr_i)
                5'(`OFS_EDGE_SELECT): next_ext_edge_select = wr_merge(ext_edge_select, `EDGE_MASK);
                5'(`OFS_CONTROL_A):   next_control_a = wr_merge(primary_irq_control_a, `CA_MASK);
                5'(`OFS_CONTROL_B):   next_control_b = wr_merge(primary_irq_control_b, 8'hFF);
                5'(`OFS_SHARED_A):    next_shared_a = wr_merge(shared_irq_group_a, shared_mask());
                `OFS_EVT_STATUS: begin
                    if (sel_i[0]) begin
                        next_evt_status = evt_status & ~dat_i[`NUM_EVT-1:0];
                    end
                end
                `OFS_EVT_MASK: begin
                    if (sel_i[0]) begin
                        next_evt_mask = dat_i[`NUM_EVT-1:0];
                    end
                end
                default: next_bus_state = irq_bank_pkg::BUS_ACK;
            endcase
        end else if (rd_req) begin
            next_bus_state = irq_bank_pkg::BUS_ACK;
            case (adr_i)
                5'(`OFS_EDGE_SELECT): next_rd_data = {24'h000000, ext_edge_select};
                5'(`OFS_CONTROL_A):   next_rd_data = {24'h000000, primary_irq_control_a};
                5'(`OFS_CONTROL_B):   next_rd_data = {24'h000000, primary_irq_control_b};
                5'(`OFS_SHARED_A):    next_rd_data = {24'h000000, shared_irq_group_a};
                `OFS_EVT_STATUS:      next_rd_data = {28'h0000000, evt_status};
                `OFS_EVT_MASK:        next_rd_data = {28'h0000000, evt_mask};
                default:              next_rd_data = 32'h00000000;
            endcase
        end

        // on service entry the served pin or time-base flag drops and global enable clears
        if (service_enter_i & core_irq_req_o) begin
            next_control_a[`CA_GLOBAL_EN] = 1'b0;
            case (pick)
                3'h0: next_control_a[`CA_PIN_A_FLAG] = 1'b0;
                3'h1: next_control_a[`CA_PIN_B_FLAG] = 1'b0;
                3'h2: next_control_a[`CA_TB0_FLAG] = 1'b0;
                3'h3: next_control_b[`CB_TB1_FLAG] = 1'b0;
                // shared flags are left for software to clear
                default: ;
            endcase
        end

        // set wins over any clear in the same cycle
        next_shared_a   = next_shared_a | sa_evt;
        next_control_a  = next_control_a | ca_evt;
        next_control_b  = next_control_b | cb_evt;
        next_evt_status = next_evt_status | {service_done_i, service_enter_i & core_irq_req_o,
                                             |cb_evt[7:4], |ca_evt[6:4]};
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_edge_select       <= `REG_RESET;
            primary_irq_control_a <= `REG_RESET;
            primary_irq_control_b <= `REG_RESET;
            shared_irq_group_a    <= `REG_RESET;
            evt_status            <= '0;
            evt_mask              <= '0;
            bus_state             <= irq_bank_pkg::BUS_IDLE;
            rd_data               <= 32'h00000000;
        end else if (ce_i) begin
            ext_edge_select       <= next_ext_edge_select;
            primary_irq_control_a <= next_control_a;
            primary_irq_control_b <= next_control_b;
            shared_irq_group_a    <= next_shared_a;
            evt_status            <= next_evt_status;
            evt_mask              <= next_evt_mask;
            bus_state             <= next_bus_state;
            rd_data               <= next_rd_data;
        end
    end
endmodule

// File: irq_core_model.sv
// core side model: takes a pending request when allowed, reports entry and return
`timescale 1ns/1ps
module irq_core_model (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic accept_i,
    input  wire logic req_i,
    output logic      enter_o,
    output logic      done_o
);
    logic [1:0] busy;

    // accept_i lets the bench make the core answer promptly or late
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            enter_o <= 1'b0;
            done_o  <= 1'b0;
            busy    <= 2'h0;
        end else begin
            enter_o <= accept_i && req_i && busy == 2'h0 && !enter_o;
            done_o  <= busy == 2'h1;
            busy    <= enter_o ? 2'h3 : (busy != 2'h0 ? busy - 2'h1 : 2'h0);
        end
    end
endmodule

// File: mcu_interrupt_flag_enable_bank_assertions.sv
// concurrent checks on the bank's bus answer and request outputs
`timescale 1ns/1ps
module irq_bank_checker (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        ce_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [4:0]  adr_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    input wire logic        service_enter_i,
    input wire logic        core_irq_req_o,
    input wire logic        irq_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    ack_pulse_a: assert property (ack_o && ce_i |=> !ack_o)
        else $error("ack longer than one cycle");
    ack_answer_a: assert property (cyc_i && stb_i && ce_i && !ack_o |=> ack_o)
        else $error("request not answered next cycle");
    ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("ack without request");
    reset_clear_a: assert property ($past(rst_i) |-> !ack_o && dat_o == 32'h0 && !core_irq_req_o && !irq_o)
        else $error("outputs not cleared by reset");
    upper_zero_a: assert property (dat_o[31:8] == 24'h0)
        else $error("upper read bits not zero");
    ctrl_msb_a: assert property (ack_o && $past(!we_i && adr_i == 5'h04) |-> !dat_o[7])
        else $error("control a bit 7 not zero");
    edge_high_a: assert property (ack_o && $past(!we_i && adr_i == 5'h00) |-> dat_o[7:4] == 4'h0)
        else $error("edge select upper bits not zero");
    service_drop_a: assert property (service_enter_i && core_irq_req_o && ce_i |=> !core_irq_req_o)
        else $error("request stays after service entry");
    unmapped_zero_a: assert property (ack_o && $past(!we_i && adr_i > 5'h14) |-> dat_o == 32'h0)
        else $error("unmapped read not zero");

    cover property (ack_o && $past(we_i));
    cover property (service_enter_i && core_irq_req_o);
    cover property (irq_o);
endmodule

bind mcu_interrupt_flag_enable_bank irq_bank_checker chk_i (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .service_enter_i(service_enter_i),
    .core_irq_req_o(core_irq_req_o), .irq_o(irq_o));

// File: mcu_interrupt_flag_enable_bank_tb.sv
// self-checking bench for the interrupt flag and enable bank
`timescale 1ns/1ps
module mcu_interrupt_flag_enable_bank_tb;
    logic        clk_i, rst_i, cyc, stb, we, ack_o, pin_a, pin_b, enter, done, accept, req, irq, ce;
    logic [4:0]  adr;
    logic [31:0] dat_i, dat_o;
    logic [5:0]  evt;
    logic [1:0]  src;
    logic [2:0]  vec;
    logic [7:0]  q;
    int          fails = 0;
    int          n_checks = 0;
    int          cycles = 0;
    // address, write value, read-back value
    localparam logic [20:0] ROWS [9] = '{{5'h00, 8'hFF, 8'h0F}, {5'h00, 8'h06, 8'h06}, {5'h04, 8'hFE, 8'h7E},
        {5'h04, 8'h00, 8'h00}, {5'h0C, 8'hFF, 8'hFF}, {5'h0C, 8'h00, 8'h00}, {5'h08, 8'hFF, 8'hFF},
        {5'h08, 8'h00, 8'h00}, {5'h18, 8'hFF, 8'h00}};

    mcu_interrupt_flag_enable_bank uut (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .ext_irq_pin_a_i(pin_a),
        .ext_irq_pin_b_i(pin_b), .time_base_zero_evt_i(evt[0]), .time_base_one_evt_i(evt[1]),
        .timer_zero_cmp_p_evt_i(evt[2]), .timer_zero_cmp_a_evt_i(evt[3]), .timer_two_cmp_p_evt_i(evt[4]),
        .timer_two_cmp_a_evt_i(evt[5]), .shared_vec_one_src_i(src[0]), .shared_vec_two_src_i(src[1]),
        .service_enter_i(enter), .service_done_i(done), .core_irq_req_o(req), .core_irq_vector_o(vec),
        .irq_o(irq));

    irq_core_model core (.clk_i(clk_i), .rst_i(rst_i), .accept_i(accept), .req_i(req), .enter_o(enter),
        .done_o(done));

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // entered just after an edge; the request holds until ack is sampled
    task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_i <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        if (n == 50) fails++;
        q = dat_o[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [4:0] a, input logic [7:0] exp);
        wb(1'b0, a, 8'h00);
        chk(q, exp);
    endtask

    task automatic end_sim;
        $display("checks=%0d fails=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            end_sim();
        end
    end

    initial begin
        rst_i = 1'b1;
        ce = 1'b1;
        {cyc, stb, we, pin_a, pin_b, accept} = 6'h00;
        {adr, dat_i, evt, src} = '0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk({6'h0, req, irq}, 8'h00);
        for (int i = 0; i < 24; i += 4) rd(5'(i), 8'h00);
        foreach (ROWS[i]) begin
            wb(1'b1, ROWS[i][20:16], ROWS[i][15:8]);
            rd(ROWS[i][20:16], ROWS[i][7:0]);
        end
        // every trigger mode on both pins, enables left off
        for (int m = 0; m < 4; m++) begin
            wb(1'b1, 5'h00, {4'h0, 2'(m), 2'(m)});
            pin_a <= 1'b1;
            pin_b <= 1'b1;
            repeat (6) @(posedge clk_i);
            rd(5'h04, {2'b00, {2{m[0]}}, 4'h0});
            wb(1'b1, 5'h04, 8'h00);
            pin_a <= 1'b0;
            pin_b <= 1'b0;
            repeat (6) @(posedge clk_i);
            rd(5'h04, {2'b00, {2{m[1]}}, 4'h0});
            wb(1'b1, 5'h04, 8'h00);
        end
        wb(1'b1, 5'h00, 8'h00);
        evt <= 6'h3F;
        src <= 2'h3;
        @(posedge clk_i);
        evt <= 6'h00;
        src <= 2'h0;
        repeat (2) @(posedge clk_i);
        rd(5'h04, 8'h40);
        rd(5'h08, 8'hD0);
        rd(5'h0C, 8'hF0);
        wb(1'b1, 5'h0C, 8'hF4);
        rd(5'h08, 8'hF0);
        wb(1'b1, 5'h08, 8'h00);
        wb(1'b1, 5'h0C, 8'h00);
        wb(1'b1, 5'h04, 8'h48);
        chk({7'h0, req}, 8'h00);
        wb(1'b1, 5'h04, 8'h49);
        chk({4'h0, req, vec}, 8'h0A);
        accept <= 1'b1;
        repeat (8) @(posedge clk_i);
        accept <= 1'b0;
        rd(5'h04, 8'h08);
        rd(5'h10, 8'h0F);
        chk({7'h0, irq}, 8'h00);
        wb(1'b1, 5'h14, 8'h04);
        chk({7'h0, irq}, 8'h01);
        rd(5'h14, 8'h04);
        // write one clears only the service entry bit
        wb(1'b1, 5'h10, 8'h04);
        chk({7'h0, irq}, 8'h00);
        rd(5'h10, 8'h0B);
        // an event while the clock enable is low must not reach any flag
        ce <= 1'b0;
        evt <= 6'h01;
        repeat (2) @(posedge clk_i);
        evt <= 6'h00;
        ce <= 1'b1;
        rd(5'h04, 8'h08);
        // reset in mid-run clears everything again
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk({6'h0, req, irq}, 8'h00);
        rd(5'h08, 8'h00);
        rd(5'h10, 8'h00);
        end_sim();
    end
endmodule
